// ===== adc_port_params.svh
// Constants of the ADC serial port controller: register offsets,
// field positions, reset values and word sizes.
// Included by the package, the port module, the monitor and the testbench; holds definitions only.
`ifndef ADC_PORT_PARAMS_SVH
`define ADC_PORT_PARAMS_SVH

// Serial word layout
`define WORD_BITS 16
`define RESULT_BITS 12
`define CHAN_BITS 4
`define FRAME_COUNT_BITS 5
`define LAST_EDGE 5'h0F
`define FRAME_DONE 5'h10

// APB register byte offsets
`define ADDR_BITS 12
`define REG_ENABLE 12'h000
`define REG_RESULT 12'h004
`define REG_CONTROL 12'h008
`define REG_SEQUENCE 12'h00C
`define REG_FRAMES 12'h010

// Field positions
`define ENABLE_BIT 0
`define RESULT_NEW_BIT 16

// Reset values
`define ENABLE_RESET 1'h1
`define CONTROL_RESET 16'h0000
`define SEQUENCE_RESET 16'h0000
`define FRAMES_RESET 16'h0000

`endif

// ===== adc_port_pkg.sv
// Types shared by the ADC serial port controller.
// Assumes adc_port_params.svh is on the include path.
`include "adc_port_params.svh"

package adc_port_pkg;

    // Control word as shifted in on the serial data input
    typedef struct packed {
        logic write;
        logic [6:0] spare;
        logic shadow;
        logic seq;
        logic coding;
        logic range_double;
        logic [`CHAN_BITS-1:0] chan;
    } ctrl_t;

    // Output word: channel address then result, MSB first
    typedef struct packed {
        logic [`CHAN_BITS-1:0] chan;
        logic [`RESULT_BITS-1:0] result;
    } out_word_t;

    // Channel stepping modes, from the sequence and shadow bits
    typedef enum logic [1:0] {
        SEQ_SINGLE = 2'b00,
        SEQ_LOAD = 2'b01,
        SEQ_RANGE = 2'b11,
        SEQ_MASK = 2'b10
    } seq_mode_t;

endpackage : adc_port_pkg

// ===== adc_serial_port.sv
// ADC serial host port: frame sync, serial clock, data in and data out,
// control and sequence registers, channel selection and APB status.
// Assumes an APB master on CLOCK_IN, a host driving the serial link, and
// a converter core whose result is valid at each frame's last falling edge.
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_params.svh"

module adc_serial_port
    import adc_port_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK_IN,
    input wire logic RST_N_IN,
    // APB slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [`ADDR_BITS-1:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [3:0] PSTRB_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // ADC serial link
    input wire logic ADC_SERIAL_CLOCK_IN,
    input wire logic ADC_FRAME_SYNC_N_IN,
    input wire logic ADC_SERIAL_DATA_IN_IN,
    output logic ADC_SERIAL_DATA_OUT_OUT,
    // Converter core
    input wire logic [`RESULT_BITS-1:0] CORE_RESULT_IN,
    output logic [`CHAN_BITS-1:0] MUX_SELECT_OUT,
    output logic HOLD_OUT,
    output logic RANGE_DOUBLE_OUT
);

    ////////////////////////////////////////////////////////////////////////
    // Decoding functions

    // Sequence and shadow bits together pick how the channel steps
    function automatic seq_mode_t mode_of(input ctrl_t c);
        seq_mode_t m;
        m = SEQ_SINGLE;
        unique case ({c.seq, c.shadow})
            2'b00: m = SEQ_SINGLE;
            2'b01: m = SEQ_LOAD;
            2'b11: m = SEQ_RANGE;
            2'b10: m = SEQ_MASK;
        endcase
        return m;
    endfunction : mode_of

    // Next set bit of the mask after cur, wrapping; cur if mask is empty
    function automatic logic [`CHAN_BITS-1:0] next_in_mask(
        input logic [`WORD_BITS-1:0] mask,
        input logic [`CHAN_BITS-1:0] cur
    );
        logic [`CHAN_BITS-1:0] found;
        logic [`CHAN_BITS-1:0] probe;
        logic hit;
        found = cur;
        hit = 1'b0;
        for (int i = 1; i <= `WORD_BITS; i++)
        begin
            probe = cur + i[`CHAN_BITS-1:0];
            if (!hit && mask[probe])
            begin
                found = probe;
                hit = 1'b1;
            end
        end
        return found;
    endfunction : next_in_mask

    // First channel of a sequence that is just being started
    function automatic logic [`CHAN_BITS-1:0] first_chan(
        input ctrl_t c,
        input logic [`WORD_BITS-1:0] mask
    );
        logic [`CHAN_BITS-1:0] f;
        f = c.chan;
        if (mode_of(c) == SEQ_RANGE)
            f = 4'h0;
        else if (mode_of(c) == SEQ_MASK)
            f = next_in_mask(mask, 4'hF);
        return f;
    endfunction : first_chan

    ////////////////////////////////////////////////////////////////////////
    // Link domain: crossings in

    logic lrst_meta;
    logic lrst_n;
    logic len_meta;
    logic len_sync;
    logic port_enable;

    // Reset and enable reach the link on its own falling edges
    always_ff @(negedge ADC_SERIAL_CLOCK_IN)
    begin
        lrst_meta <= RST_N_IN;
        lrst_n <= lrst_meta;
        len_meta <= port_enable;
        len_sync <= len_meta;
    end

    ////////////////////////////////////////////////////////////////////////
    // Link domain: frame shifter

    logic [`FRAME_COUNT_BITS-1:0] bit_count;
    logic [`WORD_BITS-1:0] rx_shift;
    logic [`WORD_BITS-1:0] tx_shift;
    logic dout;
    logic hold;
    out_word_t tx_word;
    ctrl_t ctrl;
    logic [`WORD_BITS-1:0] seq_mask;
    logic load_pending;
    logic [`CHAN_BITS-1:0] cur_chan;
    logic done_toggle;

    wire first_edge = (bit_count == 5'h00);
    wire last_edge = (bit_count == `LAST_EDGE);
    wire frame_last = last_edge && len_sync;
    wire [`WORD_BITS-1:0] rx_word = {rx_shift[`WORD_BITS-2:0],
                                     ADC_SERIAL_DATA_IN_IN};
    wire ctrl_t rx_ctrl = ctrl_t'(rx_word);
    wire [`WORD_BITS-1:0] tx_bits = tx_word;

    // Frame sync high ends the frame even when the clock has stopped
    always_ff @(negedge ADC_SERIAL_CLOCK_IN or posedge ADC_FRAME_SYNC_N_IN)
    begin
        if (ADC_FRAME_SYNC_N_IN)
        begin
            bit_count <= 5'h00;
            dout <= 1'b0;
            hold <= 1'b0;
            rx_shift <= 16'h0000;
            tx_shift <= 16'h0000;
        end
        else
        begin
            if (bit_count != `FRAME_DONE)
                bit_count <= bit_count + 5'h01;
            rx_shift <= rx_word;
            if (first_edge)
            begin
                hold <= 1'b1;
                dout <= len_sync & tx_bits[`WORD_BITS-1];
                tx_shift <= {tx_bits[`WORD_BITS-2:0], 1'b0};
            end
            else if (bit_count == `FRAME_DONE)
            begin
                dout <= 1'b0;
            end
            else
            begin
                dout <= len_sync & tx_shift[`WORD_BITS-1];
                tx_shift <= {tx_shift[`WORD_BITS-2:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link domain: control, sequence and result at frame end

    wire seq_mode_t cur_mode = mode_of(ctrl);
    wire [`CHAN_BITS-1:0] range_next = (cur_chan == ctrl.chan) ? 4'h0 :
                                       cur_chan + 4'h1;
    wire [`CHAN_BITS-1:0] mask_next = next_in_mask(seq_mask, cur_chan);
    wire [`CHAN_BITS-1:0] step_chan =
        (cur_mode == SEQ_RANGE) ? range_next :
        (cur_mode == SEQ_MASK) ? mask_next : ctrl.chan;
    // Twos complement is the straight code with its top bit flipped
    wire [`RESULT_BITS-1:0] coded = ctrl.coding ?
        {~CORE_RESULT_IN[`RESULT_BITS-1], CORE_RESULT_IN[`RESULT_BITS-2:0]} :
        CORE_RESULT_IN;

    // A frame cut short never reaches the last edge and changes nothing
    always_ff @(negedge ADC_SERIAL_CLOCK_IN)
    begin
        if (!lrst_n)
        begin
            ctrl <= ctrl_t'(`CONTROL_RESET);
            seq_mask <= `SEQUENCE_RESET;
            load_pending <= 1'b0;
            cur_chan <= 4'h0;
            tx_word <= out_word_t'(16'h0000);
            done_toggle <= 1'b0;
        end
        else if (!ADC_FRAME_SYNC_N_IN && frame_last)
        begin
            // Result of this frame's conversion goes out in the next frame
            tx_word <= '{chan: cur_chan, result: coded};
            done_toggle <= ~done_toggle;
            // A mask load frame keeps the channel; the next write starts it
            if (load_pending)
            begin
                seq_mask <= rx_word;
                load_pending <= 1'b0;
                cur_chan <= first_chan(ctrl, rx_word);
            end
            else if (rx_ctrl.write)
            begin
                ctrl <= rx_ctrl;
                load_pending <= (mode_of(rx_ctrl) == SEQ_LOAD);
                cur_chan <= first_chan(rx_ctrl, seq_mask);
            end
            else
            begin
                cur_chan <= step_chan;
            end
        end
    end

    assign ADC_SERIAL_DATA_OUT_OUT = dout;
    assign HOLD_OUT = hold;
    assign MUX_SELECT_OUT = cur_chan;
    assign RANGE_DOUBLE_OUT = ctrl.range_double;

    ////////////////////////////////////////////////////////////////////////
    // Bus domain: frame-end crossing

    logic tog_meta;
    logic tog_sync;
    logic tog_prev;
    out_word_t last_word;
    ctrl_t ctrl_seen;
    logic [`WORD_BITS-1:0] mask_seen;
    logic result_new;
    logic [`WORD_BITS-1:0] frames;

    // Link words stay still for a whole frame after the toggle moves
    wire frame_seen = tog_sync ^ tog_prev;

    always_ff @(posedge CLOCK_IN)
    begin
        tog_meta <= done_toggle;
        tog_sync <= tog_meta;
        tog_prev <= tog_sync;
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus domain: APB slave

    logic pready;
    logic pslverr;
    logic [31:0] prdata;

    // Unmapped offsets answer with an error; read-only writes drop quietly
    wire access = PSEL_IN && PENABLE_IN;
    wire done = access && pready;
    wire hit_enable = (PADDR_IN == `REG_ENABLE);
    wire hit_result = (PADDR_IN == `REG_RESULT);
    wire hit_control = (PADDR_IN == `REG_CONTROL);
    wire hit_sequence = (PADDR_IN == `REG_SEQUENCE);
    wire hit_frames = (PADDR_IN == `REG_FRAMES);
    wire mapped = hit_enable || hit_result || hit_control ||
                  hit_sequence || hit_frames;
    wire wr_enable = done && PWRITE_IN && hit_enable && PSTRB_IN[0];
    wire rd_result = done && !PWRITE_IN && hit_result;
    wire [31:0] result_view = {15'h0, result_new, last_word};
    wire [31:0] read_mux =
        hit_enable ? {31'h0, port_enable} :
        hit_result ? result_view :
        hit_control ? {16'h0000, ctrl_seen} :
        hit_sequence ? {16'h0000, mask_seen} :
        hit_frames ? {16'h0000, frames} : 32'h00000000;
    wire next_pready = access && !pready;

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RST_N_IN)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= next_pready;
            pslverr <= next_pready && !mapped;
            prdata <= (next_pready && !PWRITE_IN) ? read_mux : 32'h00000000;
        end
    end

    always_ff @(posedge CLOCK_IN)
    begin
        if (!RST_N_IN)
            port_enable <= `ENABLE_RESET;
        else if (wr_enable)
            port_enable <= PWDATA_IN[`ENABLE_BIT];
    end

    // A new frame in the same cycle as the read keeps the flag set
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RST_N_IN)
            result_new <= 1'b0;
        else if (frame_seen)
            result_new <= 1'b1;
        else if (rd_result)
            result_new <= 1'b0;
    end

    always_ff @(posedge CLOCK_IN)
    begin
        if (!RST_N_IN)
        begin
            last_word <= out_word_t'(16'h0000);
            ctrl_seen <= ctrl_t'(`CONTROL_RESET);
            mask_seen <= `SEQUENCE_RESET;
            frames <= `FRAMES_RESET;
        end
        else if (frame_seen)
        begin
            last_word <= tx_word;
            ctrl_seen <= ctrl;
            mask_seen <= seq_mask;
            frames <= frames + 16'h0001;
        end
    end

    assign PREADY_OUT = pready;
    assign PSLVERR_OUT = pslverr;
    assign PRDATA_OUT = prdata;

endmodule : adc_serial_port

`default_nettype wire

// ===== adc_port_monitor.sv
// Checker for the ADC serial port: bus handshake and link framing.
// Bound to adc_serial_port from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_params.svh"

module adc_port_monitor
(
    // Bus side
    input wire logic CLOCK_IN,
    input wire logic RST_N_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    // Link side
    input wire logic ADC_SERIAL_CLOCK_IN,
    input wire logic ADC_FRAME_SYNC_N_IN,
    input wire logic ADC_SERIAL_DATA_OUT_OUT,
    input wire logic [`CHAN_BITS-1:0] MUX_SELECT_OUT,
    input wire logic HOLD_OUT,
    input wire logic RANGE_DOUBLE_OUT
);
    ////////////////////////////////////////////////////////////////////
    a_ready_wait: assert property (@(posedge CLOCK_IN)
        disable iff (!RST_N_IN)
        PSEL_IN && !PENABLE_IN |=> !PREADY_OUT ##1 PREADY_OUT)
        else $error("ready not in second access cycle");
    a_ready_pulse: assert property (@(posedge CLOCK_IN)
        disable iff (!RST_N_IN) PREADY_OUT |=> !PREADY_OUT)
        else $error("ready longer than one cycle");
    a_err_ready: assert property (@(posedge CLOCK_IN)
        disable iff (!RST_N_IN) PSLVERR_OUT |-> PREADY_OUT)
        else $error("error without ready");
    a_rdata_idle: assert property (@(posedge CLOCK_IN)
        disable iff (!RST_N_IN) !PREADY_OUT |-> PRDATA_OUT == 32'h0)
        else $error("read data outside answer");
    ////////////////////////////////////////////////////////////////////
    a_hold_idle: assert property (@(negedge ADC_SERIAL_CLOCK_IN)
        disable iff (!RST_N_IN) ADC_FRAME_SYNC_N_IN |-> !HOLD_OUT)
        else $error("hold outside frame");
    a_hold_start: assert property (@(negedge ADC_SERIAL_CLOCK_IN)
        disable iff (!RST_N_IN) !ADC_FRAME_SYNC_N_IN && !HOLD_OUT
        |=> HOLD_OUT || ADC_FRAME_SYNC_N_IN)
        else $error("hold not raised by first edge");
    a_dout_idle: assert property (@(negedge ADC_SERIAL_CLOCK_IN)
        disable iff (!RST_N_IN)
        ADC_FRAME_SYNC_N_IN |-> !ADC_SERIAL_DATA_OUT_OUT)
        else $error("data out driven outside frame");
    a_chan_steady: assert property (@(negedge ADC_SERIAL_CLOCK_IN)
        disable iff (!RST_N_IN) ADC_FRAME_SYNC_N_IN
        |=> $stable(MUX_SELECT_OUT) && $stable(RANGE_DOUBLE_OUT))
        else $error("channel or range moved between frames");
    c_frame: cover property (@(negedge ADC_SERIAL_CLOCK_IN) $fell(HOLD_OUT));
    c_error: cover property (@(posedge CLOCK_IN) PSLVERR_OUT);
    c_read: cover property (@(posedge CLOCK_IN) PRDATA_OUT != 32'h0);
endmodule : adc_port_monitor
`default_nettype wire

// ===== host_link.sv
// Host model of the ADC link: frame sync, serial clock and control data.
// Clock idles high and runs only inside frames or when asked to.
`timescale 1ns/1ps
`default_nettype none

module host_link
(
    // Link
    output logic sclk_out,
    output logic sync_n_out,
    output logic din_out,
    input wire logic dout_in
);
    initial
    begin
        sclk_out = 1'b1;
        sync_n_out = 1'b1;
        din_out = 1'b0;
    end

    // Edges with the frame closed, so the link logic can reset
    task automatic pulses(input int n);
        repeat (n)
        begin
            #7.5 sclk_out = 1'b0;
            #7.5 sclk_out = 1'b1;
        end
    endtask : pulses

    // A frame of n falling edges; fewer than 16 aborts it
    task automatic frame(input logic [15:0] w, input int n,
        output logic [15:0] r);
        r = 16'h0000;
        sync_n_out = 1'b0;
        #5;
        for (int i = 15; i > 15 - n; i--)
        begin
            din_out = w[i];
            #7.5 sclk_out = 1'b0;
            #7.5 sclk_out = 1'b1;
            r[i] = dout_in;
        end
        #5 sync_n_out = 1'b1;
        // Inverted so a stale level is never mistaken for data
        din_out = ~din_out;
    endtask : frame
endmodule : host_link
`default_nettype wire

// ===== tb_adc_serial_port.sv
// Testbench: APB master, host link model and converter core stand-in.
// Bus copies of link state are read a few bus cycles after the last frame of a test.
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_params.svh"

module tb_adc_serial_port
    import adc_port_pkg::*;
;
    typedef struct packed
    {
        logic [15:0] ctrl;
        logic [11:0] core;
        logic [15:0] word;
    } row_t;
    // Word seen in a frame is channel and coded result of the frame before
    row_t rows [6] = '{'{16'h8003, 12'h5A5, 16'h0000},
        '{16'h8015, 12'h123, 16'h05A5}, '{16'h802F, 12'h800, 16'h3123},
        '{16'h8020, 12'hFFF, 16'h5800}, '{16'h8007, 12'h001, 16'hF7FF},
        '{16'h8007, 12'h000, 16'h0801}};
    // Sequence frames: word shifted in, then the channel it must leave
    logic [19:0] seq_rows [10] = '{20'h80800, 20'h01240, 20'h80402,
        20'h00005, 20'h00008, 20'h00002, 20'h80C20, 20'h00001,
        20'h00002, 20'h00000};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [11:0] core = 12'h000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sclk;
    logic sync_n;
    logic din;
    logic dout;
    logic [3:0] mux;
    logic hold;
    logic range_dbl;
    int n_fail = 0;
    int n_checks = 0;

    always #12.5 clk = ~clk;

    adc_serial_port adc_serial_port_inst (.CLOCK_IN(clk), .RST_N_IN(rst_n),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .ADC_SERIAL_CLOCK_IN(sclk), .ADC_FRAME_SYNC_N_IN(sync_n),
        .ADC_SERIAL_DATA_IN_IN(din), .ADC_SERIAL_DATA_OUT_OUT(dout),
        .CORE_RESULT_IN(core), .MUX_SELECT_OUT(mux), .HOLD_OUT(hold),
        .RANGE_DOUBLE_OUT(range_dbl));
    host_link host_link_inst (.sclk_out(sclk), .sync_n_out(sync_n),
        .din_out(din), .dout_in(dout));

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int t;
        t = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            t++;
        end
        while (pready !== 1'b1 && t < 50);
        if (t >= 50)
            n_fail++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [31:0] q;
        logic e;
        logic [15:0] r;
        host_link_inst.pulses(4);
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        host_link_inst.pulses(4);
        apb(1'b0, `REG_ENABLE, 32'h0, q, e);
        chk(q, 32'h1);
        apb(1'b0, `REG_FRAMES, 32'h0, q, e);
        chk(q, 32'h0);
        chk({28'h0, mux}, 32'h0);
        $display("reset test done");
        foreach (rows[k])
        begin
            @(posedge clk);
            core <= rows[k].core;
            @(posedge clk);
            host_link_inst.frame(rows[k].ctrl, 16, r);
            chk({16'h0, r}, {16'h0, rows[k].word});
            chk({27'h0, range_dbl, mux}, {27'h0, rows[k].ctrl[4:0]});
        end
        repeat (6) @(posedge clk);
        apb(1'b0, `REG_RESULT, 32'h0, q, e);
        chk(q, 32'h0001_7000);
        apb(1'b0, `REG_RESULT, 32'h0, q, e);
        chk(q, 32'h0000_7000);
        apb(1'b0, `REG_CONTROL, 32'h0, q, e);
        chk(q, 32'h0000_8007);
        $display("table test done");
        host_link_inst.frame(16'h8009, 8, r);
        repeat (6) @(posedge clk);
        apb(1'b0, `REG_FRAMES, 32'h0, q, e);
        chk(q, 32'h6);
        apb(1'b0, `REG_CONTROL, 32'h0, q, e);
        chk(q, 32'h0000_8007);
        chk({28'h0, mux}, 32'h7);
        host_link_inst.frame(16'h8009, 16, r);
        chk({16'h0, r}, 32'h7000);
        apb(1'b0, 12'h020, 32'h0, q, e);
        chk({e, q[30:0]}, 32'h8000_0000);
        pstrb <= 4'h0;
        apb(1'b1, `REG_ENABLE, 32'h0, q, e);
        pstrb <= 4'hF;
        apb(1'b0, `REG_ENABLE, 32'h0, q, e);
        chk(q, 32'h1);
        $display("abort and bus test done");
        foreach (seq_rows[k])
        begin
            @(posedge clk);
            host_link_inst.frame(seq_rows[k][19:4], 16, r);
            chk({28'h0, mux}, {28'h0, seq_rows[k][3:0]});
        end
        repeat (6) @(posedge clk);
        apb(1'b0, `REG_SEQUENCE, 32'h0, q, e);
        chk(q, 32'h0000_0124);
        apb(1'b0, `REG_FRAMES, 32'h0, q, e);
        chk(q, 32'h11);
        $display("sequence test done");
        apb(1'b1, `REG_ENABLE, 32'h0, q, e);
        host_link_inst.pulses(2);
        host_link_inst.frame(16'h8005, 16, r);
        chk({16'h0, r}, 32'h0);
        chk({28'h0, mux}, 32'h0);
        apb(1'b1, `REG_ENABLE, 32'h1, q, e);
        host_link_inst.pulses(2);
        host_link_inst.frame(16'h0000, 16, r);
        chk({16'h0, r}, 32'h2000);
        chk({28'h0, mux}, 32'h1);
        $display("disable test done");
        @(posedge clk);
        rst_n <= 1'b0;
        host_link_inst.pulses(4);
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        host_link_inst.pulses(4);
        apb(1'b0, `REG_FRAMES, 32'h0, q, e);
        chk(q, 32'h0);
        apb(1'b0, `REG_RESULT, 32'h0, q, e);
        chk(q, 32'h0);
        chk({27'h0, range_dbl, mux}, 32'h0);
        $display("mid-run reset test done");
        give_verdict();
    end

    // About ten microseconds of tests; ten times that means a hang
    initial
    begin
        #100000;
        n_fail++;
        give_verdict();
    end
endmodule : tb_adc_serial_port

bind adc_serial_port adc_port_monitor adc_port_monitor_inst (.*);
`default_nettype wire
